// >>> hw/fad_defines.svh
// Register offsets, field positions, reset values for the forwarding decoder
`ifndef FAD_DEFINES_SVH
`define FAD_DEFINES_SVH

`define FAD_OFS_NP_BASE 8'h20
`define FAD_OFS_NP_LIMIT 8'h22
`define FAD_OFS_PF_BASE 8'h24
`define FAD_OFS_PF_LIMIT 8'h26
`define FAD_OFS_PF_BASE_HI 8'h40
`define FAD_OFS_PF_LIMIT_HI 8'h44

`define FAD_WIN_LO 4
`define FAD_WIN_HI 15
`define FAD_NP_LOW_BITS 4'h0
`define FAD_PF_LOW_BITS 4'h1

`define FAD_RST_BASE 12'hfff
`define FAD_RST_LIMIT 12'h000
`define FAD_RST_HIGH 32'h0000_0000

`define FAD_MEM_BASE_FILL 20'h0_0000
`define FAD_MEM_LIMIT_FILL 20'hf_ffff
`define FAD_IO_BASE_FILL 12'h000
`define FAD_IO_LIMIT_FILL 12'hfff

`define FAD_FB_FIRST 32'h000a_0000
`define FAD_FB_LAST 32'h000b_ffff
`define FAD_VIO_A_FIRST 10'h3b0
`define FAD_VIO_A_LAST 10'h3bb
`define FAD_VIO_B_FIRST 10'h3c0
`define FAD_VIO_B_LAST 10'h3df
`define FAD_PAL_MASK 10'h3c6
`define FAD_PAL_ADDR 10'h3c8
`define FAD_PAL_DATA 10'h3c9

`endif

// >>> hw/fad_pkg.sv
// Types shared by the forwarding decoder and its users
package fad_pkg;
  typedef enum logic {
    FAD_SPACE_IO,
    FAD_SPACE_MEM
  } fad_space_t;
  typedef logic [63:0] fad_addr_t;
  typedef logic [11:0] fad_win_t;
endpackage

// >>> hw/fad_decoder.sv
// Forwarding address decoder of a transparent bridge, both bus sides
`timescale 1ns/100ps
`include "fad_defines.svh"

module fad_decoder #(
  parameter int ADDR_W = 64
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration space access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // Command and control bits
  input wire logic io_space_en,
  input wire logic mem_space_en,
  input wire logic bus_master_en,
  input wire logic legacy_io_alias_filter_en,
  input wire logic display_decode_en,
  input wire logic palette_snoop_en,
  input wire logic [31:12] io_window_base,
  input wire logic [31:12] io_window_limit,
  // Primary bus address phase
  input wire logic pri_valid,
  input wire fad_pkg::fad_addr_t pri_addr,
  input wire logic pri_dac,
  input wire fad_pkg::fad_space_t pri_space,
  input wire logic pri_write,
  output logic pri_claim,
  output logic pri_prefetch,
  output logic pri_single_phase,
  // Secondary bus address phase
  input wire logic sec_valid,
  input wire fad_pkg::fad_addr_t sec_addr,
  input wire logic sec_dac,
  input wire fad_pkg::fad_space_t sec_space,
  input wire logic sec_write,
  output logic sec_claim
);
  import fad_pkg::*;

  // Refuse address widths the 64-bit window compare cannot serve
  if (ADDR_W != 64) begin : g_chk
    $error("fad_decoder: ADDR_W must be 64");
  end

  // Window registers, upper 12 bits of each 16-bit register, plus the full 32-bit prefetchable upper halves
  fad_win_t np_base;
  fad_win_t np_limit;
  fad_win_t pf_base;
  fad_win_t pf_limit;
  logic [31:0] pf_base_high;
  logic [31:0] pf_limit_high;

  // Register select decode
  wire logic sel_np;
  wire logic sel_pf;
  wire logic sel_pf_bh;
  wire logic sel_pf_lh;
  assign sel_np = cfg_addr == `FAD_OFS_NP_BASE;
  assign sel_pf = cfg_addr == `FAD_OFS_PF_BASE;
  assign sel_pf_bh = cfg_addr == `FAD_OFS_PF_BASE_HI;
  assign sel_pf_lh = cfg_addr == `FAD_OFS_PF_LIMIT_HI;

  // 16-bit half write strobes for the packed base/limit dword
  wire logic wr_base;
  wire logic wr_limit;
  assign wr_base = cfg_wr && cfg_be[0];
  assign wr_limit = cfg_wr && cfg_be[1];

  // Read data: base in low half, limit in high half, low nibbles fixed
  wire logic [31:0] rd_mux;
  wire logic [15:0] np_base_rd;
  wire logic [15:0] np_limit_rd;
  wire logic [15:0] pf_base_rd;
  wire logic [15:0] pf_limit_rd;
  assign np_base_rd = {np_base, `FAD_NP_LOW_BITS};
  assign np_limit_rd = {np_limit, `FAD_NP_LOW_BITS};
  assign pf_base_rd = {pf_base, `FAD_PF_LOW_BITS};
  assign pf_limit_rd = {pf_limit, `FAD_PF_LOW_BITS};
  assign rd_mux = sel_np ? {np_limit_rd, np_base_rd} :
                  sel_pf ? {pf_limit_rd, pf_base_rd} :
                  sel_pf_bh ? pf_base_high :
                  sel_pf_lh ? pf_limit_high : 32'h0000_0000;

  // Nonprefetchable window registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      np_base <= `FAD_RST_BASE;
      np_limit <= `FAD_RST_LIMIT;
    end else if (clk_en && sel_np) begin
      if (wr_base) begin
        np_base <= cfg_wdata[`FAD_WIN_HI:`FAD_WIN_LO];
      end
      if (wr_limit) begin
        np_limit <= cfg_wdata[16+`FAD_WIN_HI:16+`FAD_WIN_LO];
      end
    end
  end

  // Prefetchable window registers, low 16-bit halves
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_base <= `FAD_RST_BASE;
      pf_limit <= `FAD_RST_LIMIT;
    end else if (clk_en && sel_pf) begin
      if (wr_base) begin
        pf_base <= cfg_wdata[`FAD_WIN_HI:`FAD_WIN_LO];
      end
      if (wr_limit) begin
        pf_limit <= cfg_wdata[16+`FAD_WIN_HI:16+`FAD_WIN_LO];
      end
    end
  end

  // Prefetchable window upper 32 bits
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_base_high <= `FAD_RST_HIGH;
      pf_limit_high <= `FAD_RST_HIGH;
    end else if (clk_en && cfg_wr) begin
      if (sel_pf_bh) begin
        pf_base_high <= cfg_wdata;
      end
      if (sel_pf_lh) begin
        pf_limit_high <= cfg_wdata;
      end
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (clk_en && cfg_rd) begin
      cfg_rdata <= rd_mux;
    end
  end

  // Full window bounds, low bits filled
  wire logic [31:0] np_lo;
  wire logic [31:0] np_hi;
  wire logic [63:0] pf_lo;
  wire logic [63:0] pf_hi;
  wire logic [31:0] io_lo;
  wire logic [31:0] io_hi;
  assign np_lo = {np_base, `FAD_MEM_BASE_FILL};
  assign np_hi = {np_limit, `FAD_MEM_LIMIT_FILL};
  assign pf_lo = {pf_base_high, pf_base, `FAD_MEM_BASE_FILL};
  assign pf_hi = {pf_limit_high, pf_limit, `FAD_MEM_LIMIT_FILL};
  assign io_lo = {io_window_base, `FAD_IO_BASE_FILL};
  assign io_hi = {io_window_limit, `FAD_IO_LIMIT_FILL};

  // Match results of one address phase
  typedef struct packed {
    logic io_win;
    logic isa_drop;
    logic vga_io;
    logic palette;
    logic np_win;
    logic pf_win;
    logic frame_buf;
  } fad_hits_t;

  // Raw matches from the two per-side matchers
  wire logic pri_m_io;
  wire logic pri_m_drop;
  wire logic pri_m_vio;
  wire logic pri_m_pal;
  wire logic pri_m_np;
  wire logic pri_m_pf;
  wire logic pri_m_fb;
  wire logic sec_m_io;
  wire logic sec_m_drop;
  wire logic sec_m_vio;
  wire logic sec_m_pal;
  wire logic sec_m_np;
  wire logic sec_m_pf;
  wire logic sec_m_fb;

  // Primary bus matcher; window bounds are shared with the secondary one
  fad_addr_match u_pri_match (
    .addr(pri_addr),
    .dac(pri_dac),
    .space(pri_space),
    .wr(pri_write),
    .io_lo(io_lo),
    .io_hi(io_hi),
    .np_lo(np_lo),
    .np_hi(np_hi),
    .pf_lo(pf_lo),
    .pf_hi(pf_hi),
    .io_win(pri_m_io),
    .isa_drop(pri_m_drop),
    .vga_io(pri_m_vio),
    .palette(pri_m_pal),
    .np_win(pri_m_np),
    .pf_win(pri_m_pf),
    .frame_buf(pri_m_fb)
  );

  // Secondary bus matcher, same windows seen from below the bridge
  fad_addr_match u_sec_match (
    .addr(sec_addr),
    .dac(sec_dac),
    .space(sec_space),
    .wr(sec_write),
    .io_lo(io_lo),
    .io_hi(io_hi),
    .np_lo(np_lo),
    .np_hi(np_hi),
    .pf_lo(pf_lo),
    .pf_hi(pf_hi),
    .io_win(sec_m_io),
    .isa_drop(sec_m_drop),
    .vga_io(sec_m_vio),
    .palette(sec_m_pal),
    .np_win(sec_m_np),
    .pf_win(sec_m_pf),
    .frame_buf(sec_m_fb)
  );

  // Per-side match results, packed in field order
  fad_hits_t pri_hits;
  fad_hits_t sec_hits;
  assign pri_hits = {pri_m_io, pri_m_drop, pri_m_vio, pri_m_pal,
                     pri_m_np, pri_m_pf, pri_m_fb};
  assign sec_hits = {sec_m_io, sec_m_drop, sec_m_vio, sec_m_pal,
                     sec_m_np, sec_m_pf, sec_m_fb};

  // Legacy display matches; snoop adds nothing once display decode is on
  wire logic pri_vga_io;
  wire logic pri_vga_mem;
  wire logic pri_snoop;
  wire logic sec_vga;
  assign pri_vga_io = display_decode_en && pri_hits.vga_io;
  assign pri_vga_mem = display_decode_en && pri_hits.frame_buf;
  assign pri_snoop = palette_snoop_en && !display_decode_en
                     && pri_hits.palette;
  assign sec_vga = (display_decode_en && (sec_hits.vga_io || sec_hits.frame_buf))
                   || (palette_snoop_en && sec_hits.palette);

  // Downstream matches on the primary side, gated by the space enables
  wire logic pri_io_match;
  wire logic pri_mem_match;
  wire logic next_pri_claim;
  assign pri_io_match = (pri_hits.io_win && !(legacy_io_alias_filter_en
                         && pri_hits.isa_drop))
                        || pri_vga_io || pri_snoop;
  assign pri_mem_match = pri_hits.np_win || pri_hits.pf_win
                         || pri_vga_mem;
  assign next_pri_claim = pri_valid &&
                          ((io_space_en && pri_io_match) ||
                           (mem_space_en && pri_mem_match));

  // Prefetch for prefetchable window reads; frame buffer reads stay single-phase
  wire logic next_pri_prefetch;
  wire logic next_pri_single;
  assign next_pri_prefetch = next_pri_claim && !pri_write && pri_hits.pf_win
                             && !pri_vga_mem;
  assign next_pri_single = next_pri_claim && !pri_write
                           && pri_vga_mem;

  // Secondary addresses that belong below the bridge are ignored there
  wire logic sec_io_down;
  wire logic sec_mem_down;
  wire logic sec_down;
  wire logic next_sec_claim;
  assign sec_io_down = sec_hits.io_win && !(legacy_io_alias_filter_en
                       && sec_hits.isa_drop);
  assign sec_mem_down = sec_hits.np_win || sec_hits.pf_win;
  assign sec_down = sec_io_down || sec_mem_down || sec_vga;
  assign next_sec_claim = sec_valid && bus_master_en
                          && !sec_down;

  // Decode results registered one cycle after the address phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pri_claim <= 1'b0;
      pri_prefetch <= 1'b0;
      pri_single_phase <= 1'b0;
      sec_claim <= 1'b0;
    end else if (clk_en) begin
      pri_claim <= next_pri_claim;
      pri_prefetch <= next_pri_prefetch;
      pri_single_phase <= next_pri_single;
      sec_claim <= next_sec_claim;
    end
  end

endmodule

// Window and legacy range matches for one bus side's address phase
module fad_addr_match (
  input wire fad_pkg::fad_addr_t addr,
  input wire logic dac,
  input wire fad_pkg::fad_space_t space,
  input wire logic wr,
  input wire logic [31:0] io_lo,
  input wire logic [31:0] io_hi,
  input wire logic [31:0] np_lo,
  input wire logic [31:0] np_hi,
  input wire logic [63:0] pf_lo,
  input wire logic [63:0] pf_hi,
  output logic io_win,
  output logic isa_drop,
  output logic vga_io,
  output logic palette,
  output logic np_win,
  output logic pf_win,
  output logic frame_buf
);
  import fad_pkg::*;

  // Space decode and the upper-half tests shared by every range except the prefetchable window
  wire logic is_io;
  wire logic is_mem;
  wire logic low32;
  wire logic low64k;
  wire logic [9:0] ofs;
  wire fad_addr_t pf_addr;
  assign is_io = space == FAD_SPACE_IO;
  assign is_mem = space == FAD_SPACE_MEM;
  // Single-cycle address carries zero upper half
  assign low32 = !dac && addr[63:32] == 32'h0000_0000;
  assign low64k = low32 && addr[31:16] == 16'h0000;
  assign ofs = addr[9:0];
  // Single-cycle phases compare with a zero upper half, whatever the pins show
  assign pf_addr = dac ? addr : {32'h0000_0000, addr[31:0]};

  // I/O window, plain inclusive compare, off when inverted
  assign io_win = is_io && low32 && addr[31:0] >= io_lo
                  && addr[31:0] <= io_hi;
  // Alias filter drops upper 768 bytes of each 1KB below 64KB only
  assign isa_drop = io_win && low64k && addr[9:8] != 2'b00;
  // Display I/O, 1KB aliases throughout the first 64KB
  assign vga_io = is_io && low64k &&
                  ((ofs >= `FAD_VIO_A_FIRST && ofs <= `FAD_VIO_A_LAST) ||
                   (ofs >= `FAD_VIO_B_FIRST && ofs <= `FAD_VIO_B_LAST));
  // Palette writes, same aliasing
  assign palette = is_io && wr && low64k &&
                   (ofs == `FAD_PAL_MASK || ofs == `FAD_PAL_ADDR ||
                    ofs == `FAD_PAL_DATA);
  // Nonprefetchable window is 32-bit only, no dual-address hit
  assign np_win = is_mem && low32 && addr[31:0] >= np_lo
                  && addr[31:0] <= np_hi;
  // Prefetchable window, full 64-bit inclusive compare
  assign pf_win = is_mem && pf_addr >= pf_lo && pf_addr <= pf_hi;
  // Frame buffer only; BIOS area above it is never part of it
  assign frame_buf = is_mem && low32 && addr[31:0] >= `FAD_FB_FIRST
                     && addr[31:0] <= `FAD_FB_LAST;

endmodule

// >>> sim/fad_agent.sv
// Bus initiator model presenting one address phase per request
`timescale 1ns/100ps
module fad_agent (
  input wire logic clk,
  input wire logic go,
  input wire fad_pkg::fad_addr_t a_i,
  input wire fad_pkg::fad_space_t s_i,
  output logic v,
  output fad_pkg::fad_addr_t a,
  output fad_pkg::fad_space_t s
);
  import fad_pkg::*;
  fad_addr_t last = '0;
  // Remember the last phase so released lines never repeat it
  always_ff @(posedge clk) begin
    if (go) begin
      last <= a_i;
    end
  end
  // Idle lines show the inverse of the last address
  assign v = go;
  assign a = go ? a_i : ~last;
  assign s = go ? s_i : fad_space_t'(~s_i);
endmodule

// >>> sim/fad_decoder_properties.sv
// Concurrent checks on the forwarding decoder ports
`timescale 1ns/100ps
module fad_decoder_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic io_space_en,
  input wire logic mem_space_en,
  input wire logic bus_master_en,
  input wire logic display_decode_en,
  input wire logic palette_snoop_en,
  input wire logic pri_valid,
  input wire fad_pkg::fad_addr_t pri_addr,
  input wire logic pri_dac,
  input wire fad_pkg::fad_space_t pri_space,
  input wire logic pri_write,
  input wire logic pri_claim,
  input wire logic pri_prefetch,
  input wire logic pri_single_phase,
  input wire logic sec_valid,
  input wire logic sec_claim
);
  import fad_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Primary frame-buffer read and palette write phases
  sequence fb_read;
    pri_valid && clk_en && display_decode_en && mem_space_en && pri_space == FAD_SPACE_MEM
      && !pri_write && !pri_dac && pri_addr >= 64'h000a_0000 && pri_addr <= 64'h000b_ffff;
  endsequence
  sequence pal_wr;
    pri_valid && clk_en && palette_snoop_en && io_space_en && pri_space == FAD_SPACE_IO
      && pri_write && !pri_dac && pri_addr[63:16] == 48'h0
      && pri_addr[9:0] inside {10'h3c6, 10'h3c8, 10'h3c9};
  endsequence
  chk_pri_idle_quiet: assert property (clk_en && !pri_valid |=> !pri_claim)
    else $error("primary claim without phase");
  chk_sec_idle_quiet: assert property (clk_en && !sec_valid |=> !sec_claim)
    else $error("secondary claim without phase");
  chk_prefetch_claimed: assert property (pri_prefetch |-> pri_claim && !pri_single_phase)
    else $error("bad prefetch flag");
  chk_fb_single: assert property (fb_read |=> pri_claim && pri_single_phase)
    else $error("frame buffer read not single");
  chk_no_master_up: assert property (clk_en && !bus_master_en |=> !sec_claim)
    else $error("upstream claim without master");
  chk_no_mem_down: assert property (pri_valid && clk_en && !mem_space_en
    && pri_space == FAD_SPACE_MEM |=> !pri_claim) else $error("memory claim while off");
  chk_no_io_down: assert property (pri_valid && clk_en && !io_space_en
    && pri_space == FAD_SPACE_IO |=> !pri_claim) else $error("io claim while off");
  chk_palette_claim: assert property (pal_wr |=> pri_claim)
    else $error("palette write not claimed");
endmodule
bind fad_decoder fad_decoder_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .io_space_en(io_space_en), .mem_space_en(mem_space_en), .bus_master_en(bus_master_en),
  .display_decode_en(display_decode_en), .palette_snoop_en(palette_snoop_en),
  .pri_valid(pri_valid), .pri_addr(pri_addr), .pri_dac(pri_dac), .pri_space(pri_space),
  .pri_write(pri_write), .pri_claim(pri_claim), .pri_prefetch(pri_prefetch),
  .pri_single_phase(pri_single_phase), .sec_valid(sec_valid), .sec_claim(sec_claim));

// >>> sim/tb_fad_decoder.sv
// Self-checking bench for the forwarding address decoder
`timescale 1ns/100ps
module tb_fad_decoder;
  import fad_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic [1:0] cfg_be = 2'h3;
  logic clk_en = 1'b1;
  logic io_en = 1'b0, mem_en = 1'b0, bm_en = 1'b0, filt = 1'b0, disp = 1'b0, snoop = 1'b0;
  logic [31:12] io_base = 20'h0, io_lim = 20'h1f;
  logic pg = 1'b0, sg = 1'b0, dac = 1'b0, wr = 1'b0;
  fad_addr_t a_i = '0, pa, sa;
  fad_space_t s_i = FAD_SPACE_IO, ps_sp, ss_sp;
  logic pv, sv, pc, pp, ps, sc;
  int err_total = 0, tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  fad_agent u_pri (.clk(ref_clk), .go(pg), .a_i(a_i), .s_i(s_i), .v(pv), .a(pa), .s(ps_sp));
  fad_agent u_sec (.clk(ref_clk), .go(sg), .a_i(a_i), .s_i(s_i), .v(sv), .a(sa), .s(ss_sp));
  fad_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_space_en(io_en), .mem_space_en(mem_en), .bus_master_en(bm_en),
    .legacy_io_alias_filter_en(filt), .display_decode_en(disp), .palette_snoop_en(snoop),
    .io_window_base(io_base), .io_window_limit(io_lim), .pri_valid(pv), .pri_addr(pa),
    .pri_dac(dac), .pri_space(ps_sp), .pri_write(wr), .pri_claim(pc), .pri_prefetch(pp),
    .pri_single_phase(ps), .sec_valid(sv), .sec_addr(sa), .sec_dac(dac), .sec_space(ss_sp),
    .sec_write(wr), .sec_claim(sc));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle configuration write and read strobes
  task automatic cw(input logic [7:0] ad, input logic [31:0] v);
    @(negedge ref_clk);
    cfg_addr = ad;
    cfg_wdata = v;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic cr(input logic [7:0] ad, input logic [31:0] e);
    @(negedge ref_clk);
    cfg_addr = ad;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk(cfg_rdata, e);
  endtask
  // One address phase; e is claim, prefetch, single phase
  task automatic ph(input logic sd, input fad_addr_t ad, input logic d, input fad_space_t sp,
      input logic w, input logic [2:0] e);
    @(negedge ref_clk);
    a_i = ad;
    dac = d;
    s_i = sp;
    wr = w;
    pg = !sd;
    sg = sd;
    @(negedge ref_clk);
    pg = 1'b0;
    sg = 1'b0;
    chk(sd ? {29'h0, sc, 2'h0} : {29'h0, pc, pp, ps}, {29'h0, e});
  endtask
  task automatic io(input logic sd, input fad_addr_t ad, input logic w, input logic [2:0] e);
    ph(sd, ad, 1'b0, FAD_SPACE_IO, w, e);
  endtask
  task automatic mm(input logic sd, input fad_addr_t ad, input logic d, input logic [2:0] e);
    ph(sd, ad, d, FAD_SPACE_MEM, 1'b0, e);
  endtask
  // Register reset values, masking and unmapped offsets
  task automatic t_regs();
    cr(8'h20, 32'h0000_fff0);
    cr(8'h24, 32'h0001_fff1);
    cr(8'h30, 32'h0);
    cw(8'h20, 32'h002f_001f);
    cr(8'h20, 32'h0020_0010);
    cfg_be = 2'h2;
    cw(8'h20, 32'h002f_00ff);
    cfg_be = 2'h3;
    cr(8'h20, 32'h0020_0010);
    cw(8'h24, 32'h005f_005f);
    cr(8'h24, 32'h0051_0051);
  endtask
  // Memory windows, limits, 64-bit compare and inverted windows
  task automatic t_mem();
    mm(0, 64'h10_0000, 0, 3'h4);
    mm(0, 64'h2f_ffff, 0, 3'h4);
    mm(0, 64'h30_0000, 0, 3'h0);
    mm(1, 64'h30_0000, 0, 3'h4);
    mm(1, 64'h20_0000, 0, 3'h0);
    mm(0, 64'h50_0000, 0, 3'h6);
    mm(1, 64'h5f_0000, 0, 3'h0);
    cw(8'h44, 32'h2);
    cw(8'h40, 32'h1);
    cw(8'h24, 32'h0050_0060);
    mm(0, 64'h1_8000_0000, 1, 3'h6);
    mm(0, 64'h8000_0000, 0, 3'h0);
    cw(8'h20, 32'h0020_0030);
    mm(0, 64'h20_0000, 0, 3'h0);
  endtask
  // Command enables gate each direction; a low clock enable freezes all state
  task automatic t_en();
    mem_en = 1'b0;
    mm(0, 64'h1_8000_0000, 1, 3'h0);
    mem_en = 1'b1;
    bm_en = 1'b0;
    mm(1, 64'h30_0000, 0, 3'h0);
    bm_en = 1'b1;
    clk_en = 1'b0;
    mm(1, 64'h30_0000, 0, 3'h0);
    cw(8'h40, 32'h5);
    clk_en = 1'b1;
    cr(8'h40, 32'h1);
    io_en = 1'b0;
    io(0, 64'h400, 0, 3'h0);
    io_en = 1'b1;
  endtask
  // Legacy alias filter inside and above the first 64KB
  task automatic t_io();
    filt = 1'b1;
    io(0, 64'h100, 0, 3'h0);
    io(0, 64'h4ff, 1, 3'h4);
    io(0, 64'h1_0300, 0, 3'h4);
    io(1, 64'h100, 0, 3'h4);
    io(1, 64'h400, 0, 3'h0);
    io(1, 64'h2_0000, 0, 3'h4);
    filt = 1'b0;
    io(0, 64'h100, 0, 3'h4);
  endtask
  // Display decode, then palette snooping
  task automatic t_disp();
    disp = 1'b1;
    io_base = 20'h10;
    io_lim = 20'h0f;
    mm(0, 64'ha_0000, 0, 3'h5);
    mm(1, 64'ha_0000, 0, 3'h0);
    mm(0, 64'hc_0000, 0, 3'h0);
    io(0, 64'hfbb0, 0, 3'h4);
    io(0, 64'h3bc, 0, 3'h0);
    io(0, 64'h1_03c0, 0, 3'h0);
    snoop = 1'b1;
    io(0, 64'h3c7, 0, 3'h4);
    disp = 1'b0;
    io(0, 64'h7c6, 1, 3'h4);
    io(0, 64'h3c8, 1, 3'h4);
    io(0, 64'h3c9, 0, 3'h0);
  endtask
  task automatic results();
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset, program windows before enables, then scenarios
  initial begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    t_regs();
    {io_en, mem_en, bm_en} = 3'h7;
    t_mem();
    t_en();
    t_io();
    t_disp();
    results();
  end
  // Cut a hang short
  initial begin
    #1000000;
    err_total++;
    results();
  end
endmodule
